// ### hw/bcd_op_regs.vh
// Purpose: constants for the opcode timing decoder
// Assumes: standard 8051 opcode map, single-clock cycle counting
// Notes: widths for byte lengths and cycle counts, instruction class codes
`ifndef BCD_OP_REGS_VH
`define BCD_OP_REGS_VH

// --------------------------------------------------
// widths
// --------------------------------------------------
`define BCD_OPC_W 8
`define BCD_LEN_W 2
`define BCD_CYC_W 4
`define BCD_PC_W 16

// --------------------------------------------------
// instruction class codes
// --------------------------------------------------
`define BCD_CLS_UNK 4'h0
`define BCD_CLS_ARITH 4'h1
`define BCD_CLS_INCDEC 4'h2
`define BCD_CLS_LOGIC 4'h3
`define BCD_CLS_ACCOP 4'h4
`define BCD_CLS_MOV 4'h5
`define BCD_CLS_DPLOAD 4'h6
`define BCD_CLS_CODEMOV 4'h7
`define BCD_CLS_XDMOV 4'h8
`define BCD_CLS_STACK 4'h9
`define BCD_CLS_XCH 4'hA
`define BCD_CLS_NIBXCH 4'hB

// --------------------------------------------------
// direct address space split
// --------------------------------------------------
`define BCD_SFR_BASE 8'h80

// --------------------------------------------------
// reset values
// --------------------------------------------------
`define BCD_PC_RST 16'h0000
`endif

// ### hw/bcd_op_sequencer.v
// Purpose: instruction sequencer paced by the opcode timing table
// Assumes: opcode byte is valid on opcode while fetchReq is high
// Notes: one system clock per counted cycle, no machine-cycle grouping
`include "bcd_op_regs.vh"

module bcd_op_sequencer #(
    parameter PC_W = 16 // program counter width
) (
    input wire clk,
    input wire rst,
    input wire [7:0] opcode,
    input wire [7:0] operand1,
    input wire [1:0] bankSel,
    input wire flashWriteEn,
    input wire [7:0] accIn,
    input wire [7:0] ramIn,
    output reg [PC_W-1:0] pc_q,
    output wire fetchReq,
    output reg [1:0] lenOut_q,
    output reg [3:0] cycOut_q,
    output reg [3:0] classOut_q,
    output reg unknownOp_q,
    output reg directIsSfr_q,
    output reg [4:0] bankRegAddr_q,
    output reg flashTarget_q,
    output reg xdWide_q,
    output reg [7:0] nibAccOut_q,
    output reg [7:0] nibRamOut_q
);
    // --------------------------------------------------
    // state encoding, one-hot
    // --------------------------------------------------
    localparam ST_FETCH = 2'b01; // opcode being taken
    localparam ST_EXEC = 2'b10;  // counting execution cycles

    reg [1:0] state_q;
    reg [3:0] cnt_q;       // cycles left in current instruction
    reg [1:0] pendLen_q;   // bytes to add at completion

    // --------------------------------------------------
    // lookup table
    // --------------------------------------------------
    wire [1:0] tLen;
    wire [3:0] tCyc;
    wire [3:0] tCls;
    wire tKnown;

    bcd_op_table uTable (
        .opcode(opcode),
        .byteLen(tLen),
        .cycleCnt(tCyc),
        .opClass(tCls),
        .known(tKnown)
    );

    // fetch handshake is combinational on state
    assign fetchReq = state_q[0];

    // --------------------------------------------------
    // sequencer: counts each clock as one cycle
    // --------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_FETCH;
            cnt_q <= 4'h0;
            pendLen_q <= 2'h0;
            pc_q <= {PC_W{1'b0}};
            lenOut_q <= 2'h0;
            cycOut_q <= 4'h0;
            classOut_q <= 4'h0;
            unknownOp_q <= 1'b0;
            directIsSfr_q <= 1'b0;
            bankRegAddr_q <= 5'h00;
            flashTarget_q <= 1'b0;
            xdWide_q <= 1'b0;
            nibAccOut_q <= 8'h00;
            nibRamOut_q <= 8'h00;
        end else begin
            case (state_q)
                ST_FETCH: begin
                    lenOut_q <= tLen;
                    cycOut_q <= tCyc;
                    classOut_q <= tCls;
                    unknownOp_q <= ~tKnown;
                    // direct address split
                    directIsSfr_q <= (operand1 >= `BCD_SFR_BASE);
                    // bank register in active bank
                    bankRegAddr_q <= {bankSel, opcode[2:0]};
                    // external move: flash or external data
                    flashTarget_q <= (tCls == `BCD_CLS_XDMOV) & flashWriteEn;
                    xdWide_q <= (tCls == `BCD_CLS_XDMOV) & ~opcode[1];
                    // low nibble swap only
                    if (tCls == `BCD_CLS_NIBXCH) begin
                        nibAccOut_q <= {accIn[7:4], ramIn[3:0]};
                        nibRamOut_q <= {ramIn[7:4], accIn[3:0]};
                    end
                    pendLen_q <= tLen;
                    // one clock already spent
                    if (tCyc == 4'd1) begin
                        pc_q <= pc_q + {{(PC_W-2){1'b0}}, tLen};
                    end else begin
                        cnt_q <= tCyc - 4'd1;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    // hold off next fetch until count elapses
                    if (cnt_q == 4'd1) begin
                        pc_q <= pc_q + {{(PC_W-2){1'b0}}, pendLen_q};
                        state_q <= ST_FETCH;
                    end
                    cnt_q <= cnt_q - 4'd1;
                end
                default: begin
                    state_q <= ST_FETCH;
                end
            endcase
        end
    end
endmodule

// ### hw/bcd_op_table.v
// Purpose: combinational length and cycle lookup per opcode
// Assumes: opcode is the first instruction byte
// Notes: unknown opcodes report length 1, cycles 1, known low
`include "bcd_op_regs.vh"

module bcd_op_table (
    input wire [7:0] opcode,
    output reg [1:0] byteLen,
    output reg [3:0] cycleCnt,
    output reg [3:0] opClass,
    output reg known
);
    // --------------------------------------------------
    // decode by row (high nibble) and column (low nibble)
    // --------------------------------------------------
    wire [3:0] hi = opcode[7:4];
    wire [3:0] lo = opcode[3:0];
    wire isBank = lo[3];                 // bank register columns 8..F
    wire isInd = (lo == 4'h6) || (lo == 4'h7); // indirect pointer register

    // lookup; one case per row keeps the table readable
    always @* begin
        byteLen = 2'd1;
        cycleCnt = 4'd1;
        opClass = `BCD_CLS_UNK;
        known = 1'b0;
        case (hi)
            4'h2, 4'h3, 4'h9: begin // add, add_with_carry, subtract_with_borrow
                if (lo >= 4'h4) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_ARITH;
                    // register 1/1, indirect 1/2, direct or immediate 2/2
                    if (isBank) begin
                        byteLen = 2'd1; cycleCnt = 4'd1;
                    end else if (isInd) begin
                        byteLen = 2'd1; cycleCnt = 4'd2;
                    end else begin
                        byteLen = 2'd2; cycleCnt = 4'd2;
                    end
                end
            end
            4'h0, 4'h1: begin // increment, decrement
                if (lo >= 4'h4) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_INCDEC;
                    // accumulator and bank forms 1/1
                    if (isBank || lo == 4'h4) begin
                        byteLen = 2'd1; cycleCnt = 4'd1;
                    end else if (isInd) begin
                        byteLen = 2'd1; cycleCnt = 4'd2;
                    end else begin
                        byteLen = 2'd2; cycleCnt = 4'd2;
                    end
                end
            end
            4'h4, 4'h5, 4'h6: begin // or_operation, and_operation, exclusive_or_operation
                if (lo >= 4'h2) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_LOGIC;
                    // into direct: from accumulator 2/2, from immediate 3/3
                    if (lo == 4'h3) begin
                        byteLen = 2'd3; cycleCnt = 4'd3;
                    end else if (isBank) begin
                        byteLen = 2'd1; cycleCnt = 4'd1;
                    end else if (isInd) begin
                        byteLen = 2'd1; cycleCnt = 4'd2;
                    end else begin
                        byteLen = 2'd2; cycleCnt = 4'd2;
                    end
                end
            end
            4'h7: begin // immediate moves, move to indirect; 0x70 etc are branches
                if (lo == 4'h4 || lo >= 4'h6) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_MOV;
                    byteLen = 2'd2; cycleCnt = 4'd2;
                end else if (lo == 4'h5) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_MOV;
                    byteLen = 2'd3; cycleCnt = 4'd3;
                end
            end
            4'h8: begin
                if (lo == 4'h3) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_CODEMOV;
                    byteLen = 2'd1; cycleCnt = 4'd3;
                end else if (lo == 4'h5) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_MOV;
                    byteLen = 2'd3; cycleCnt = 4'd3;
                end else if (lo >= 4'h6) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_MOV;
                    byteLen = 2'd2; cycleCnt = 4'd2;
                end
            end
            4'hA: begin
                if (lo == 4'h3) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_INCDEC;
                    byteLen = 2'd1; cycleCnt = 4'd1;
                end else if (lo >= 4'h6) begin
                    known = 1'b1;
                    opClass = `BCD_CLS_MOV;
                    byteLen = 2'd2; cycleCnt = 4'd2;
                end
            end
            default: begin
                known = 1'b0;
            end
        endcase
        // single-opcode forms outside the row pattern
        case (opcode)
            8'h90: begin
                known = 1'b1; opClass = `BCD_CLS_DPLOAD;
                byteLen = 2'd3; cycleCnt = 4'd3;
            end
            8'h93: begin
                known = 1'b1; opClass = `BCD_CLS_CODEMOV;
                byteLen = 2'd1; cycleCnt = 4'd3;
            end
            8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
                known = 1'b1; opClass = `BCD_CLS_XDMOV;
                byteLen = 2'd1; cycleCnt = 4'd3;
            end
            8'hC0, 8'hD0: begin
                known = 1'b1; opClass = `BCD_CLS_STACK;
                byteLen = 2'd2; cycleCnt = 4'd2;
            end
            8'hE4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: begin
                known = 1'b1; opClass = `BCD_CLS_ACCOP;
                byteLen = 2'd1; cycleCnt = 4'd1;
            end
            8'hC5: begin
                known = 1'b1; opClass = `BCD_CLS_XCH;
                byteLen = 2'd2; cycleCnt = 4'd2;
            end
            8'hC6, 8'hC7: begin
                known = 1'b1; opClass = `BCD_CLS_XCH;
                byteLen = 2'd1; cycleCnt = 4'd2;
            end
            8'hD6, 8'hD7: begin
                known = 1'b1; opClass = `BCD_CLS_NIBXCH;
                byteLen = 2'd1; cycleCnt = 4'd2;
            end
            8'hE5, 8'hF5, 8'hE6, 8'hE7, 8'hF6, 8'hF7: begin
                known = 1'b1; opClass = `BCD_CLS_MOV;
                byteLen = (opcode[2:0] == 3'h5) ? 2'd2 : 2'd1;
                cycleCnt = (opcode[2:0] == 3'h5) ? 4'd2 : 4'd2;
            end
            default: begin
                if (hi == 4'hC && isBank) begin
                    known = 1'b1; opClass = `BCD_CLS_XCH;
                    byteLen = 2'd1; cycleCnt = 4'd1;
                end else if ((hi == 4'hE || hi == 4'hF) && isBank) begin
                    known = 1'b1; opClass = `BCD_CLS_MOV;
                    byteLen = 2'd1; cycleCnt = 4'd1;
                end
            end
        endcase
    end
endmodule

// ### sim/bcd_op_sequencer_properties.sv
// Purpose: port-level timing and decode checks on the sequencer
// Assumes: one clock, async active high reset
// Notes: decoded outputs are judged one edge after a take
module bcd_op_sequencer_properties #(
    parameter PC_W = 16
) (
    input wire clk,
    input wire rst,
    input wire [7:0] opcode,
    input wire [7:0] operand1,
    input wire [1:0] bankSel,
    input wire flashWriteEn,
    input wire [7:0] accIn,
    input wire [7:0] ramIn,
    input wire [PC_W-1:0] pc_q,
    input wire fetchReq,
    input wire [1:0] lenOut_q,
    input wire [3:0] cycOut_q,
    input wire [3:0] classOut_q,
    input wire unknownOp_q,
    input wire directIsSfr_q,
    input wire [4:0] bankRegAddr_q,
    input wire flashTarget_q,
    input wire [7:0] nibAccOut_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // external data move first bytes, both address widths
    wire isXdMove = (opcode[7:5] == 3'h7) && (opcode[3:2] == 2'h0) && (opcode[1:0] != 2'h1);
    a_fetch_after_reset: assert property ($past(rst) |-> fetchReq)
        else $error("no fetch right after reset");
    a_single_back2back: assert property (fetchReq |=> fetchReq == (cycOut_q == 4'h1))
        else $error("fetch gap wrong after take");
    a_two_cycle_gap: assert property (fetchReq ##1 (cycOut_q == 4'h2) |-> !fetchReq ##1 fetchReq)
        else $error("two cycle op gap wrong");
    a_three_cycle_gap: assert property (fetchReq ##1 (cycOut_q == 4'h3) |-> !fetchReq [*2] ##1 fetchReq)
        else $error("three cycle op gap wrong");
    a_pc_adds_len: assert property ($changed(pc_q) |-> fetchReq && pc_q == $past(pc_q) + lenOut_q)
        else $error("pc step differs from length");
    a_take_moves_pc: assert property (fetchReq && !$past(rst) |-> $changed(pc_q))
        else $error("pc did not advance before take");
    a_unknown_single: assert property (fetchReq ##1 unknownOp_q |-> lenOut_q == 2'h1 && cycOut_q == 4'h1)
        else $error("undecoded op not 1 byte 1 cycle");
    a_outputs_stand: assert property (!fetchReq |=> $stable(lenOut_q) && $stable(cycOut_q))
        else $error("decode changed without take");
    a_bank_field: assert property (fetchReq |=> bankRegAddr_q == ({$past(bankSel), 3'h0} | ($past(opcode) & 8'h07)))
        else $error("bank register address wrong");
    a_direct_split: assert property (fetchReq |=> directIsSfr_q == ($past(operand1) >= 8'h80))
        else $error("direct space split wrong");
    a_flash_route: assert property (fetchReq && isXdMove |=> flashTarget_q == $past(flashWriteEn))
        else $error("flash target wrong");
    // external move class code must follow a take of such a first byte
    a_class_xdmove: assert property (fetchReq && isXdMove |=> classOut_q == 4'h8)
        else $error("external move class wrong");
    a_nibble_swap: assert property (fetchReq && opcode[7:1] == 7'h6B |=>
        nibAccOut_q == (($past(accIn) & 8'hF0) | ($past(ramIn) & 8'h0F)))
        else $error("low nibble exchange wrong");
    // main scenarios reached
    c_three_cycle: cover property (fetchReq ##1 (cycOut_q == 4'h3));
    c_unknown: cover property (fetchReq ##1 unknownOp_q);
    c_flash_move: cover property (fetchReq && isXdMove && flashWriteEn);
endmodule
bind bcd_op_sequencer bcd_op_sequencer_properties #(.PC_W(PC_W)) chk_inst (.clk, .rst, .opcode, .operand1,
    .bankSel, .flashWriteEn, .accIn, .ramIn, .pc_q, .fetchReq, .lenOut_q, .cycOut_q, .classOut_q, .unknownOp_q,
    .directIsSfr_q, .bankRegAddr_q, .flashTarget_q, .nibAccOut_q);

// ### sim/bcd_op_sequencer_tb.sv
// Purpose: self-checking bench for the opcode sequencer
// Assumes: program image loaded while reset is high
// Notes: one image holding every first byte, then random images
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, a, e); end end
module bcd_op_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0; // 20 MHz system clock
    logic rst = 1'b1; // async reset
    logic wrEn = 1'b0; // image load strobe
    logic [9:0] wrAddr = 10'h000;
    logic [7:0] wrData = 8'h00;
    logic [1:0] bankSel = 2'h0;
    logic flashWriteEn = 1'b0;
    logic [7:0] accIn = 8'h00, ramIn = 8'h00;
    wire [7:0] opcode, operand1, nibAccOut_q, nibRamOut_q;
    wire [15:0] pc_q;
    wire fetchReq, unknownOp_q, directIsSfr_q, flashTarget_q, xdWide_q;
    wire [1:0] lenOut_q;
    wire [3:0] cycOut_q, classOut_q;
    wire [4:0] bankRegAddr_q;
    integer seed = 28, num_errors = 0, tests_run = 0, gap = 0;
    logic armed = 1'b0; // a previous take is pending
    logic [15:0] expPc;
    logic [3:0] expGap;
    logic [6:0] e;
    always #25 clk = ~clk;
    bcd_prog_mem bcd_prog_mem_inst (.clk, .wrEn, .wrAddr, .wrData, .pc(pc_q), .opcode, .operand1);
    bcd_op_sequencer bcd_op_sequencer_inst (.clk, .rst, .opcode, .operand1, .bankSel, .flashWriteEn, .accIn,
        .ramIn, .pc_q, .fetchReq, .lenOut_q, .cycOut_q, .classOut_q, .unknownOp_q, .directIsSfr_q,
        .bankRegAddr_q, .flashTarget_q, .xdWide_q, .nibAccOut_q, .nibRamOut_q);
    // ----------------------------------------
    // expected {known, bytes, cycles} per first byte
    // ----------------------------------------
    function automatic logic [6:0] expect_op(input logic [7:0] op);
        logic [3:0] h, l;
        h = op[7:4];
        l = op[3:0];
        expect_op = 7'h11; // undecoded: 1 byte, 1 cycle
        if ((h < 4'h4 || h == 4'h9) && l >= 4'h4 || h >= 4'h4 && h <= 4'h6 && l >= 4'h2) begin
            case (l)
                4'h3: expect_op = 7'h73;
                4'h6, 4'h7: expect_op = 7'h52;
                4'h2, 4'h4, 4'h5: expect_op = (h < 4'h2 && l == 4'h4) ? 7'h51 : 7'h62;
                default: expect_op = 7'h51;
            endcase
        end
        case (op) inside
            8'h03, 8'h13, 8'h23, 8'h33, 8'hA3, 8'hC4, 8'hE4: expect_op = 7'h51;
            8'h75, 8'h85, 8'h90: expect_op = 7'h73;
            8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: expect_op = 7'h53;
            8'h74, 8'h76, 8'h77, 8'h86, 8'h87, 8'hA6, 8'hA7, 8'hC0, 8'hC5, 8'hD0, 8'hE5, 8'hF5,
            [8'h78:8'h7F], [8'h88:8'h8F], [8'hA8:8'hAF]: expect_op = 7'h62;
            8'hC6, 8'hC7, 8'hD6, 8'hD7, 8'hE6, 8'hE7, 8'hF6, 8'hF7: expect_op = 7'h52;
            [8'hC8:8'hCF], [8'hE8:8'hEF], [8'hF8:8'hFF]: expect_op = 7'h51;
            default: ;
        endcase
    endfunction
    // decode outputs once the take edge has landed
    task automatic chk_decode(input logic [7:0] op, d, input logic [1:0] b, input logic f, input logic [7:0] a, r);
        logic [6:0] x;
        logic mx;
        x = expect_op(op);
        mx = (x[3:0] == 4'h3) && (op[7:5] == 3'h7);
        #2;
        `CHK(lenOut_q, x[5:4])
        `CHK(cycOut_q, x[3:0])
        `CHK(unknownOp_q, ~x[6])
        `CHK(directIsSfr_q, d[7])
        `CHK(bankRegAddr_q, {b, op[2:0]})
        `CHK(flashTarget_q, mx & f)
        if (mx) `CHK(xdWide_q, ~op[1])
        if (mx) `CHK(classOut_q, 4'h8)
        if (op[7:1] == 7'h6B) begin
            `CHK(nibAccOut_q, {a[7:4], r[3:0]})
            `CHK(nibRamOut_q, {r[7:4], a[3:0]})
            `CHK(classOut_q, 4'hB)
        end
    endtask
    // ----------------------------------------
    // monitor: spacing and pc of the previous op at each take
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            armed = 1'b0;
        end else begin
            gap = gap + 1;
            if (fetchReq === 1'b1) begin
                if (armed) begin
                    `CHK(pc_q, expPc)
                    `CHK(gap, expGap)
                end else `CHK(pc_q, 16'h0000)
                e = expect_op(opcode);
                expPc = pc_q + e[5:4];
                expGap = e[3:0];
                gap = 0;
                armed = 1'b1;
                chk_decode(opcode, operand1, bankSel, flashWriteEn, accIn, ramIn);
            end
        end
    end
    // reset, load an image, then run it under random side inputs
    task automatic run_image(input logic exhaustive, input integer cycles);
        logic [7:0] img [0:1023];
        logic [6:0] x;
        integer i, p;
        p = 0;
        rst = 1'b1;
        for (i = 0; i < 1024; i++) img[i] = $random(seed);
        for (i = 0; i < 256 && exhaustive; i++) begin
            img[p] = i[7:0];
            x = expect_op(i[7:0]);
            p = p + x[5:4];
        end
        for (i = 0; i < 1024 + cycles; i++) begin
            @(posedge clk);
            #5;
            wrEn = (i < 1024);
            wrAddr = i[9:0];
            wrData = img[i[9:0]];
            rst = (i < 1025);
            {bankSel, flashWriteEn} = $random(seed);
            accIn = $random(seed);
            ramIn = $random(seed);
        end
        $display("image done, pc %h", pc_q);
    endtask
    initial begin
        run_image(1'b1, 800);
        repeat (10) run_image(1'b0, 200);
        results();
    end
    // watchdog sized from the image loads and runs
    initial begin
        #(20000 * 50);
        num_errors++;
        results();
    end
    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
endmodule

// ### sim/bcd_prog_mem.sv
// Purpose: program memory model facing the opcode sequencer
// Assumes: image is loaded while the core is held in reset
// Notes: 1 kB image; addresses wrap, so random code runs forever
module bcd_prog_mem #(
    parameter PC_W = 16
) (
    input wire clk,
    input wire wrEn,
    input wire [9:0] wrAddr,
    input wire [7:0] wrData,
    input wire [PC_W-1:0] pc,
    output logic [7:0] opcode,
    output logic [7:0] operand1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023]; // code image
    // ----------------------------------------
    // load port, bench only
    // ----------------------------------------
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
    // ----------------------------------------
    // fetch: first byte and the one after it follow pc
    // ----------------------------------------
    always_comb begin
        opcode = mem[pc[9:0]];
        operand1 = mem[pc[9:0] + 10'h001];
    end
endmodule
